/* hdl/sei_top.sv */
`timescale 1ns/1ps
module sei_top #(
	parameter int WD_UNIT_CYC = sei_pkg::WD_UNIT_CYCLES
) (
	input  wire logic                          clock,
	input  wire logic                          reset,
	input  wire logic [sei_pkg::POS_BITS-1:0]  position,
	input  wire logic                          dir_backward,
	input  wire logic                          integ_tick,
	input  wire logic [15:0]                   watchdog_interval,
	input  wire sei_pkg::sei_rx_evt_t          rx_evt,
	input  wire logic                          param_unlock,
	input  wire logic                          preset_done,
	input  wire logic                          preset_pending,
	input  wire logic                          preset_error,
	input  wire logic                          window_exceeded,
	input  wire logic                          telegram_defect,
	input  wire logic                          seq_counter_cleared,
	input  wire logic                          frame_req,
	output logic [7:0]                         tx_data,
	output logic                               tx_last,
	output logic                               tx_valid,
	input  wire logic                          tx_ready,
	output logic [15:0]                        speed_word,
	output logic [7:0]                         safety_status_byte,
	output logic                               param_error,
	output logic                               startup_blocked,
	output logic                               frame_busy
);
	logic [sei_pkg::POS_BITS-1:0] pos_prev_r;
	logic [15:0]                  speed_r;
	logic                         ovf_r;
	logic [sei_pkg::POS_BITS-1:0] delta;
	logic signed [28:0]           delta_s;
	logic signed [28:0]           speed_s;
	logic                         params_accepted_r;
	logic                         dev_fault_r;
	logic                         cksum_err_r;
	logic                         watchdog_expired_r;
	logic                         toggle_r;
	logic                         seq_counter_reset_r;
	logic                         param_error_r;
	logic                         failsafe_active;
	logic [31:0]                  prescale_r;
	logic [15:0]                  wd_units_r;
	logic                         wd_unit_tick;
	logic                         wd_fire;
	logic [7:0]                   frame_r [sei_pkg::FRAME_BYTES];
	logic [3:0]                   idx_r;
	sei_pkg::sei_tx_state_t       state_r;
	sei_pkg::sei_byte_t           push_byte;
	sei_pkg::sei_byte_t           pop_byte;
	logic                         push_valid;
	logic                         push_ready;
	logic                         frame_start;
	logic [15:0]                  rev_word;
	logic [15:0]                  step_word;
	logic [15:0]                  cams_word;
	logic [15:0]                  stat_word;
	logic [15:0]                  spd_word;

	// high or low byte of a word, used for every word of the frame
	function automatic logic [7:0] word_byte(input logic [15:0] w, input logic high);
		word_byte = high ? w[15:8] : w[7:0];
	endfunction : word_byte

	// signed increment since the last integration tick; modulo arithmetic keeps
	// a wrap of the absolute position from looking like a huge jump
	assign delta   = position - pos_prev_r;
	assign delta_s = {delta[sei_pkg::POS_BITS-1], delta};
	assign speed_s = dir_backward ? 29'(-delta_s) : delta_s;

	// speed sampled once per integration interval, saturating at the limits
	always_ff @(posedge clock) begin
		if (reset) begin
			pos_prev_r <= '0;
			speed_r    <= sei_pkg::SPEED_RST;
			ovf_r      <= 1'b0;
		end else if (integ_tick) begin
			pos_prev_r <= position;
			if (speed_s > 29'sd32767) begin
				speed_r <= sei_pkg::SPEED_MAX;
				ovf_r   <= 1'b1;
			end else if (speed_s < -29'sd32768) begin
				speed_r <= sei_pkg::SPEED_MIN;
				ovf_r   <= 1'b1;
			end else begin
				speed_r <= speed_s[15:0];
				ovf_r   <= 1'b0;
			end
		end
	end

	// preset acceptance: held while the unlock stays set, set wins over clear
	always_ff @(posedge clock) begin
		if (reset) begin
			params_accepted_r <= 1'b0;
		end else if (preset_done && param_unlock) begin
			params_accepted_r <= 1'b1;
		end else if (!param_unlock) begin
			params_accepted_r <= 1'b0;
		end
	end

	// fatal faults latch; only a power cycle (reset) releases them
	always_ff @(posedge clock) begin
		if (reset) begin
			dev_fault_r        <= 1'b0;
			watchdog_expired_r <= 1'b0;
			param_error_r      <= 1'b0;
		end else begin
			if (window_exceeded || telegram_defect) dev_fault_r <= 1'b1;
			if (wd_fire) watchdog_expired_r <= 1'b1;
			if (rx_evt.param_crc_error) param_error_r <= 1'b1;
		end
	end

	// communication flags: an error in the same cycle as a clean telegram wins
	always_ff @(posedge clock) begin
		if (reset) begin
			cksum_err_r <= 1'b0;
		end else if (rx_evt.seq_error || rx_evt.crc_error || rx_evt.param_crc_error) begin
			cksum_err_r <= 1'b1;
		end else if (rx_evt.valid) begin
			cksum_err_r <= 1'b0;
		end
	end

	// counter-reset indication lasts until the next valid telegram
	always_ff @(posedge clock) begin
		if (reset) begin
			seq_counter_reset_r <= 1'b0;
		end else if (seq_counter_cleared) begin
			seq_counter_reset_r <= 1'b1;
		end else if (rx_evt.valid) begin
			seq_counter_reset_r <= 1'b0;
		end
	end

	// toggle flips on each valid host telegram, keeping both counters in step
	always_ff @(posedge clock) begin
		if (reset) begin
			toggle_r <= 1'b0;
		end else if (rx_evt.valid) begin
			toggle_r <= !toggle_r;
		end
	end

	// watchdog time base; a zero interval means the watchdog is not yet armed
	assign wd_unit_tick = (prescale_r == 32'(WD_UNIT_CYC - 1));
	assign wd_fire      = (watchdog_interval != 16'h0000) && (wd_units_r >= watchdog_interval)
	                      && !rx_evt.valid;
	always_ff @(posedge clock) begin
		if (reset || rx_evt.valid) begin
			prescale_r <= '0;
			wd_units_r <= '0;
		end else begin
			prescale_r <= wd_unit_tick ? 32'h0000_0000 : prescale_r + 32'h0000_0001;
			if (wd_unit_tick && wd_units_r != 16'hffff) wd_units_r <= wd_units_r + 16'h0001;
		end
	end

	// fail-safe follows the latched device fault and watchdog expiry, so it too holds until reset
	assign failsafe_active = dev_fault_r || watchdog_expired_r;

	// safe status byte, top bit tied low
	always_ff @(posedge clock) begin
		if (reset) begin
			safety_status_byte <= sei_pkg::SAFE_RST;
		end else begin
			safety_status_byte[sei_pkg::SS_PARAMS_OK]  <= params_accepted_r;
			safety_status_byte[sei_pkg::SS_DEV_FAULT]  <= dev_fault_r;
			safety_status_byte[sei_pkg::SS_CKSUM_ERR]  <= cksum_err_r;
			safety_status_byte[sei_pkg::SS_WD_EXPIRED] <= watchdog_expired_r;
			safety_status_byte[sei_pkg::SS_FAILSAFE]   <= failsafe_active;
			safety_status_byte[sei_pkg::SS_TOGGLE]     <= toggle_r;
			safety_status_byte[sei_pkg::SS_SEQ_RESET]  <= seq_counter_reset_r;
			safety_status_byte[sei_pkg::SS_RESERVED]   <= 1'b0;
		end
	end

	// data words of the frame; passivated data is all zero while fail-safe
	assign rev_word  = failsafe_active ? 16'h0000 :
	                   {1'b0, pos_prev_r[sei_pkg::POS_BITS-1 -: sei_pkg::REV_BITS]};
	assign step_word = failsafe_active ? 16'h0000 :
	                   {3'b000, pos_prev_r[sei_pkg::STEP_BITS-1:0]};
	assign spd_word  = failsafe_active ? 16'h0000 : speed_r;
	assign cams_word = failsafe_active ? 16'h0000 : {15'h0000, ovf_r};
	assign stat_word = failsafe_active ? 16'h0000 :
	                   {preset_error, 14'h0000, preset_pending};

	// snapshot of a whole frame so the words never tear across bytes
	assign frame_start = frame_req && (state_r == sei_pkg::SEI_IDLE);
	always_ff @(posedge clock) begin
		if (frame_start) begin
			frame_r[sei_pkg::OFS_CAMS]     <= word_byte(cams_word, 1'b1);
			frame_r[sei_pkg::OFS_CAMS+1]   <= word_byte(cams_word, 1'b0);
			frame_r[sei_pkg::OFS_STATUS]   <= word_byte(stat_word, 1'b1);
			frame_r[sei_pkg::OFS_STATUS+1] <= word_byte(stat_word, 1'b0);
			frame_r[sei_pkg::OFS_SPEED]    <= word_byte(spd_word, 1'b1);
			frame_r[sei_pkg::OFS_SPEED+1]  <= word_byte(spd_word, 1'b0);
			frame_r[sei_pkg::OFS_REV]      <= word_byte(rev_word, 1'b1);
			frame_r[sei_pkg::OFS_REV+1]    <= word_byte(rev_word, 1'b0);
			frame_r[sei_pkg::OFS_STEP]     <= word_byte(step_word, 1'b1);
			frame_r[sei_pkg::OFS_STEP+1]   <= word_byte(step_word, 1'b0);
			frame_r[sei_pkg::OFS_SAFE]     <= safety_status_byte;
		end
	end

	// serializer; a request during a frame is ignored, the buffer stalls it
	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= sei_pkg::SEI_IDLE;
			idx_r   <= 4'h0;
		end else begin
			unique case (state_r)
				sei_pkg::SEI_IDLE: begin
					idx_r <= 4'h0;
					if (frame_start) state_r <= sei_pkg::SEI_SEND;
				end
				sei_pkg::SEI_SEND: begin
					if (push_ready) begin
						idx_r <= idx_r + 4'h1;
						if (idx_r == 4'(sei_pkg::FRAME_BYTES - 1)) state_r <= sei_pkg::SEI_IDLE;
					end
				end
			endcase
		end
	end

	assign push_valid     = (state_r == sei_pkg::SEI_SEND);
	assign push_byte.data = frame_r[idx_r];
	assign push_byte.last = (idx_r == 4'(sei_pkg::FRAME_BYTES - 1));

	// buffer decouples frame assembly from link timing
	sei_fifo #(
		.WIDTH ($bits(sei_pkg::sei_byte_t)),
		.DEPTH (sei_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset     (reset),
		.in_data   (push_byte),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.out_data  (pop_byte),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	assign tx_data         = pop_byte.data;
	assign tx_last         = pop_byte.last;
	assign speed_word      = speed_r;
	assign param_error     = param_error_r;
	assign startup_blocked = param_error_r;
	assign frame_busy      = (state_r == sei_pkg::SEI_SEND);

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence frame_begin_s;
		frame_start;
	endsequence
	sequence frame_run_s;
		frame_busy [*2];
	endsequence
	// expiry latches first, the status byte shows fail-safe one edge later; the sequence checks it two edges on
	sequence wd_latched_s;
		watchdog_expired_r ##2 safety_status_byte[sei_pkg::SS_FAILSAFE];
	endsequence

	speed_saturate_a: assert property (ovf_r |-> (speed_r == 16'h7fff || speed_r == 16'h8000))
		else $error("overflow without saturated speed");
	speed_ovf_set_a: assert property (integ_tick && speed_s > 29'sd32767 |=> ovf_r && speed_r == 16'h7fff)
		else $error("positive overflow not reported");
	speed_sign_a: assert property (integ_tick && !dir_backward && delta_s > 29'sd0 && delta_s < 29'sd100
		|=> !speed_r[15] && speed_r != 16'h0000)
		else $error("forward clockwise speed not positive");
	speed_back_a: assert property (integ_tick && dir_backward && delta_s > 29'sd0 && delta_s < 29'sd100
		|=> speed_r[15])
		else $error("backward clockwise speed not negative");
	fault_latch_a: assert property (window_exceeded || telegram_defect |=> dev_fault_r ##1 dev_fault_r)
		else $error("device fault did not latch");
	wd_latch_a: assert property (wd_fire |=> wd_latched_s)
		else $error("watchdog expiry not latched into fail-safe");
	failsafe_bit_a: assert property (failsafe_active |=> safety_status_byte[4])
		else $error("fail-safe bit missing");
	cksum_set_a: assert property (rx_evt.seq_error || rx_evt.crc_error |=> cksum_err_r)
		else $error("checksum error bit not set");
	toggle_flip_a: assert property (rx_evt.valid |=> toggle_r != $past(toggle_r))
		else $error("toggle bit did not flip");
	params_ok_a: assert property (preset_done && param_unlock |=> ##1 safety_status_byte[0])
		else $error("params accepted bit not set");
	seq_reset_a: assert property (seq_counter_cleared |=> seq_counter_reset_r)
		else $error("counter reset bit not set");
	reserved_zero_a: assert property (safety_status_byte[7] == 1'b0)
		else $error("reserved status bit set");
	frame_start_a: assert property (frame_begin_s |=> frame_run_s)
		else $error("frame did not start");

	// negative side of the saturation and the return into range
	speed_ovf_neg_a: assert property (integ_tick && speed_s < -29'sd32768
		|=> ovf_r && speed_r == sei_pkg::SPEED_MIN)
		else $error("negative overflow not reported");
	speed_clear_a: assert property (integ_tick && speed_s <= 29'sd32767 && speed_s >= -29'sd32768
		|=> !ovf_r)
		else $error("overflow flag stuck after return to range");

	// parameter checksum failures raise both indications
	param_cksum_a: assert property (rx_evt.param_crc_error |=> cksum_err_r && param_error_r)
		else $error("parameter checksum error not reported");

	// a valid telegram restarts the whole watchdog time base
	wd_restart_a: assert property (rx_evt.valid |=> wd_units_r == 16'h0000 && prescale_r == '0)
		else $error("watchdog not restarted by valid telegram");

	// latched faults must survive until the next power cycle
	fault_hold_a: assert property (dev_fault_r |=> dev_fault_r)
		else $error("device fault released without reset");
	wd_hold_a: assert property (watchdog_expired_r |=> watchdog_expired_r)
		else $error("watchdog expiry released without reset");
	fault_status_a: assert property (dev_fault_r |=> safety_status_byte[sei_pkg::SS_DEV_FAULT])
		else $error("device fault bit missing");

	// passivated frame content while fail-safe is active
	passive_data_a: assert property (failsafe_active
		|-> rev_word == 16'h0000 && step_word == 16'h0000 && spd_word == 16'h0000
		&& cams_word == 16'h0000 && stat_word == 16'h0000)
		else $error("live data sent while fail-safe");

	// the byte flagged last closes the frame on the next edge
	frame_end_a: assert property (push_valid && push_ready && push_byte.last |=> !frame_busy)
		else $error("frame did not end after last byte");

endmodule : sei_top

/* hdl/sei_pkg.sv */
package sei_pkg;

	// clock and watchdog time base
	localparam int CLK_PERIOD_NS  = 10;
	localparam int WD_UNIT_NS     = 1000000;                    // one watchdog unit is 1 ms
	localparam int WD_UNIT_CYCLES = WD_UNIT_NS / CLK_PERIOD_NS;

	// position layout
	localparam int STEP_BITS = 13;                              // 8192 steps per revolution
	localparam int REV_BITS  = 15;                              // 0 .. 32767 revolutions
	localparam int POS_BITS  = STEP_BITS + REV_BITS;

	// byte offsets inside the input telegram, high byte of each word first
	localparam int FRAME_BYTES = 11;
	localparam int OFS_CAMS    = 0;
	localparam int OFS_STATUS  = 2;
	localparam int OFS_SPEED   = 4;
	localparam int OFS_REV     = 6;
	localparam int OFS_STEP    = 8;
	localparam int OFS_SAFE    = 10;

	// field positions
	localparam int CAMS_OVF_BIT      = 0;
	localparam int STAT_PRESET_BIT   = 0;
	localparam int STAT_PRESET_ERR   = 15;
	localparam int SS_PARAMS_OK      = 0;
	localparam int SS_DEV_FAULT      = 1;
	localparam int SS_CKSUM_ERR      = 2;
	localparam int SS_WD_EXPIRED     = 3;
	localparam int SS_FAILSAFE       = 4;
	localparam int SS_TOGGLE         = 5;
	localparam int SS_SEQ_RESET      = 6;
	localparam int SS_RESERVED       = 7;

	// speed limits of the signed 16-bit word
	localparam logic [15:0] SPEED_MAX = 16'h7fff;
	localparam logic [15:0] SPEED_MIN = 16'h8000;

	// values after reset
	localparam logic [15:0] SPEED_RST  = 16'h0000;
	localparam logic [7:0]  SAFE_RST   = 8'h00;

	// output buffer
	localparam int FIFO_DEPTH = 8;

	// one telegram byte on its way to the link
	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} sei_byte_t;

	// events reported by the receive side for one host telegram
	typedef struct packed {
		logic valid;
		logic seq_error;
		logic crc_error;
		logic param_crc_error;
	} sei_rx_evt_t;

	typedef enum {SEI_IDLE, SEI_SEND} sei_tx_state_t;

endpackage : sei_pkg

/* hdl/sei_fifo.sv */
`timescale 1ns/1ps
module sei_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage, written only on an accepted push
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// pointers wrap by index; depth is a power of two here
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_r    <= '0;
			rd_r    <= '0;
			count_r <= '0;
		end else begin
			if (push) wr_r <= wr_r + 1'b1;
			if (pop) rd_r <= rd_r + 1'b1;
			if (push && !pop) count_r <= count_r + 1'b1;
			else if (pop && !push) count_r <= count_r - 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// the fill count itself must never pass the depth, whatever the flags say
	fifo_no_overrun_a: assert property (count_r <= (AW+1)'(DEPTH))
		else $error("fifo accepts data while full");
	fifo_count_track_a: assert property (push && !pop |=> count_r == $past(count_r) + 1'b1)
		else $error("fifo count missed a push");

endmodule : sei_fifo

/* sim/sei_host_model.sv */
`timescale 1ns/1ps
// host side sink of the input telegram; it stalls often so the buffer fills and refuses
module sei_host_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic       toggle_bit
);
	logic [7:0] frame_r [0:10];
	int         n_byte_r;
	int         last_at_r;
	int         n_frames_r = 0;
	int         vcn_r = 0;
	logic       toggle_seen_r = 1'b0;
	int         n_bad_r = 0;
	logic       host_safe;

	// the host tolerates up to BAD_LIMIT bad telegrams, none here, so the first one sends it safe
	localparam int BAD_LIMIT = 0;
	assign host_safe = (n_bad_r > BAD_LIMIT);

	// ready moves just after the edge, busy three cycles in four
	initial tx_ready = 1'b0;
	always @(posedge clock) begin
		tx_ready <= #1 ($urandom_range(3) == 0);
	end

	// bytes are taken only at an edge where valid and ready are both high
	always @(posedge clock) begin
		if (reset) begin
			n_byte_r <= 0;
		end else if (tx_valid && tx_ready && n_byte_r < 11) begin
			frame_r[n_byte_r] <= tx_data;
			n_byte_r          <= tx_last ? 0 : n_byte_r + 1;
			if (tx_last) begin
				last_at_r  <= n_byte_r;
				n_frames_r <= n_frames_r + 1;
				// the last byte is the safe status; its checksum bit marks a bad telegram
				if (tx_data[sei_pkg::SS_CKSUM_ERR]) n_bad_r <= n_bad_r + 1;
			end
		end
	end

	// every change of the device toggle outside reset advances the virtual consecutive number
	always @(posedge clock) begin
		toggle_seen_r <= toggle_bit;
		if (!reset && toggle_bit != toggle_seen_r) begin
			vcn_r <= vcn_r + 1;
		end
	end
endmodule : sei_host_model

/* sim/sei_top_tb.sv */
`timescale 1ns/1ps
module sei_top_tb;
	localparam int WD_CYC = 10;
	logic                         clock = 1'b0;
	logic                         reset = 1'b1;
	logic [sei_pkg::POS_BITS-1:0] position = '0;
	logic [sei_pkg::POS_BITS-1:0] prev;
	logic [15:0]                  watchdog_interval;
	sei_pkg::sei_rx_evt_t         rx_evt, ev;
	logic                         dir_backward, integ_tick, param_unlock, preset_done;
	logic                         preset_pending, preset_error, window_exceeded;
	logic                         telegram_defect, seq_counter_cleared, frame_req, clr;
	logic [7:0]                   tx_data, safety_status_byte, ss_exp;
	logic                         tx_last, tx_valid, tx_ready, param_error;
	logic                         startup_blocked, frame_busy;
	logic [15:0]                  speed_word;
	logic [16:0]                  last_e;
	int                           n_mismatch = 0;
	int                           samples_checked = 0;
	int                           d;

	always #5 clock = ~clock;

	sei_top #(.WD_UNIT_CYC(WD_CYC)) i_dut (.clock(clock), .reset(reset), .position(position),
		.dir_backward(dir_backward), .integ_tick(integ_tick),
		.watchdog_interval(watchdog_interval), .rx_evt(rx_evt), .param_unlock(param_unlock),
		.preset_done(preset_done), .preset_pending(preset_pending),
		.preset_error(preset_error), .window_exceeded(window_exceeded),
		.telegram_defect(telegram_defect), .seq_counter_cleared(seq_counter_cleared),
		.frame_req(frame_req), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .speed_word(speed_word), .safety_status_byte(safety_status_byte),
		.param_error(param_error), .startup_blocked(startup_blocked), .frame_busy(frame_busy));

	sei_host_model i_host (.clock(clock), .reset(reset), .tx_data(tx_data), .tx_last(tx_last),
		.tx_valid(tx_valid), .tx_ready(tx_ready),
		.toggle_bit(safety_status_byte[sei_pkg::SS_TOGGLE]));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask : chk

	task automatic end_sim();
		$display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	// every drive lands one nanosecond after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	// expected speed with overflow flag on top; the wrap of the 28-bit count is kept
	function automatic logic [16:0] exp_speed(logic [27:0] now, logic [27:0] old, logic back);
		logic signed [27:0] dd;
		int                 v;
		dd = now - old;
		v = back ? -int'(dd) : int'(dd);
		if (v > 32767) return {1'b1, 16'h7fff};
		if (v < -32768) return {1'b1, 16'h8000};
		return {1'b0, v[15:0]};
	endfunction : exp_speed

	// safe status after one receive event; a set beats a clear in the same cycle
	function automatic logic [7:0] next_ss(logic [7:0] s, sei_pkg::sei_rx_evt_t e, logic c,
		logic unl, logic dn);
		logic [7:0] n;
		n = s;
		n[0] = unl & (s[0] | dn);
		if (e.valid) begin
			n[5] = ~s[5];
			n[2] = 1'b0;
			n[6] = 1'b0;
		end
		if (e.seq_error | e.crc_error | e.param_crc_error) n[2] = 1'b1;
		if (c) n[6] = 1'b1;
		return n;
	endfunction : next_ss

	// reset stands in for a power cycle
	task automatic power_up();
		reset = 1'b1;
		step(6);
		reset = 1'b0;
		prev = '0;
		last_e = '0;
		chk("status after reset", 8'h00, safety_status_byte);
		chk("speed after reset", 16'h0000, speed_word);
	endtask : power_up

	task automatic tick(input logic [27:0] p, input logic back);
		last_e = exp_speed(p, prev, back);
		position = p;
		dir_backward = back;
		integ_tick = 1'b1;
		step(1);
		integ_tick = 1'b0;
		step(1);
		chk("speed", {16'h0, last_e[15:0]}, speed_word);
		prev = p;
	endtask : tick

	// one telegram through the buffer; passivated frames carry zeros before the safe byte
	task automatic frame(input logic [7:0] ss, input logic pas);
		logic [15:0] w [0:4];
		logic [7:0]  e [0:10];
		int          f0;
		f0 = i_host.n_frames_r;
		w[0] = {15'h0, last_e[16]};
		w[1] = {preset_error, 14'h0, preset_pending};
		w[2] = last_e[15:0];
		w[3] = {1'b0, prev[27:13]};
		w[4] = {3'h0, prev[12:0]};
		for (int i = 0; i < 5; i++) begin
			e[2 * i] = pas ? 8'h00 : w[i][15:8];
			e[2 * i + 1] = pas ? 8'h00 : w[i][7:0];
		end
		e[10] = ss;
		chk("busy before request", 1'b0, frame_busy);
		frame_req = 1'b1;
		step(1);
		frame_req = 1'b0;
		for (int i = 0; i < 300 && i_host.n_frames_r == f0; i++) step(1);
		chk("frames seen", f0 + 1, i_host.n_frames_r);
		for (int i = 0; i < 11; i++) chk("telegram byte", e[i], i_host.frame_r[i]);
		chk("last byte index", 10, i_host.last_at_r);
	endtask : frame

	// hang guard of 10000 cycles, far beyond the thousand or so cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		void'($urandom(7));
		{dir_backward, integ_tick, param_unlock, preset_done, preset_pending} = '0;
		{preset_error, window_exceeded, telegram_defect, seq_counter_cleared, frame_req} = '0;
		rx_evt = '0;
		watchdog_interval = 16'h0000;
		power_up();
		// corner deltas first: both overflows, the exact limits, a small clockwise step
		// in each direction, then random
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 40000 : (i == 1) ? -50000 : (i == 2) ? 32767 : (i == 3) ? -32768 :
				(i < 6) ? 50 : int'($urandom_range(60000)) - 30000;
			preset_pending = $urandom_range(1);
			preset_error = $urandom_range(1);
			tick(prev + d[27:0], (i == 5) ? 1'b1 : (i > 5) ? $urandom_range(1) : 1'b0);
			frame(8'h00, 1'b0);
		end
		// receive events at random, the last one with a bad parameter checksum
		ss_exp = 8'h00;
		for (int i = 0; i < 24; i++) begin
			ev = '0;
			ev.valid = 1'b1;
			ev.seq_error = ($urandom_range(3) == 0);
			ev.crc_error = ($urandom_range(3) == 0);
			ev.param_crc_error = (i == 23);
			clr = $urandom_range(1);
			param_unlock = ($urandom_range(2) != 0);
			preset_done = param_unlock & $urandom_range(1);
			rx_evt = ev;
			seq_counter_cleared = clr;
			ss_exp = next_ss(ss_exp, ev, clr, param_unlock, preset_done);
			step(1);
			{rx_evt, seq_counter_cleared, preset_done} = '0;
			step(3);
			chk("safe status", ss_exp, safety_status_byte);
		end
		chk("param error latch", 2'b11, {param_error, startup_blocked});
		frame(ss_exp, 1'b0);
		chk("host sequence number", 24, i_host.vcn_r);
		chk("host bad telegrams", 1, i_host.n_bad_r);
		chk("host safe state", 1'b1, i_host.host_safe);
		// watchdog of three units fed in time, then starved
		watchdog_interval = 16'h0003;
		power_up();
		for (int i = 0; i < 5; i++) begin
			step(11);
			rx_evt = 4'h8;
			step(1);
			rx_evt = '0;
			chk("watchdog early", 1'b0, safety_status_byte[3]);
		end
		step(50);
		chk("watchdog expired", 8'h38, safety_status_byte);
		frame(8'h38, 1'b1);
		rx_evt = 4'h8;
		step(1);
		rx_evt = '0;
		step(5);
		chk("watchdog latched", 2'b11, safety_status_byte[4:3]);
		// both fatal fault causes, each after its own power cycle
		watchdog_interval = 16'h0000;
		for (int k = 0; k < 2; k++) begin
			power_up();
			window_exceeded = (k == 0);
			telegram_defect = (k == 1);
			step(1);
			{window_exceeded, telegram_defect} = '0;
			step(20);
			chk("device fault", 8'h12, safety_status_byte);
			frame(8'h12, 1'b1);
		end
		end_sim();
	end
endmodule : sei_top_tb
